// ---- alarm_src.sv ----
// far-side model: crystal detector and a watchdog restarting agent
`timescale 1ns/1ps
module alarm_src (
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic xtal_kill,
    input  wire logic starve,
    output logic      xtal_stopped,
    output logic      wdog_active,
    output logic      wdog_restart
);
    logic [2:0] tick_r;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tick_r       <= 3'h0;
            xtal_stopped <= 1'b0;
            wdog_active  <= 1'b0;
            wdog_restart <= 1'b0;
        end else begin
            tick_r       <= tick_r + 3'h1;
            xtal_stopped <= xtal_kill;
            wdog_active  <= 1'b1;
            // restart every eight cycles unless told to starve the watchdog
            wdog_restart <= !starve && tick_r == 3'h7;
        end
    end
endmodule

// ---- nmi_fault_irq_enable.sv ----
// top-level enables, non-maskable alarm sources, bus fault causes, axi4-lite registers
`timescale 1ns/1ps
`include "nmi_fault_params.svh"

// Notes on behaviour
// - non-maskable interrupt comes only from crystal failure and watchdog warning flags.
// - crystal stopping while selected switches system clock to internal RC oscillator.
// - crystal-fail flag rises only after detection and switchover both finished.
// - active watchdog not restarted for 1.792 s raises warning flag.
// - each bus fault cause has its own status bit; several may set together.
// - byte/halfword peripheral-bus access or unaligned word access flags bad width.
// - unprivileged write to system peripheral or protected RAM flags protection fault.
// - access above last implemented register inside peripheral 4 kB block flags reserved.
// - access beyond implemented RAM or flash top also flags reserved.
// - fault while another is recorded sets missed bit.
// - second fault raises hard fault, which overrides the bus fault exception.
// - enable-set write of one enables a line; zero leaves it alone.
// - bit 16 debug, bits 15..12 external pins, bit 11 converter.
// - bits 10, 9, 8 radio receive, transmit, timer lines.
// - bits 7..4 security, serial two, serial one, sleep timer; 3..0 baseband..timer one.
// - enable-set register resets to zero; all lines start disabled.
// - pending line reaches core only while enabled, even if enabled later.
// - enabled second-level flags of one source OR into one level request.
// - flags set regardless of mask; write one clears; zero has no effect.
// - enabled repeat before clear is dropped and sets missed bit, write-one cleared.
module nmi_fault_irq_enable
    import nmi_fault_pkg::*;
#(
    parameter int    WDOG_WARN_CYCLES = `WDOG_WARN_CYC,
    parameter int    SWITCH_CYCLES    = `CLK_SWITCH_CYC,
    parameter word_t RAM_TOP          = `RAM_TOP_DEF,
    parameter word_t FLASH_TOP        = `FLASH_TOP_DEF
) (
    input  wire logic                  core_clk,
    input  wire logic                  srst,
    input  wire logic [31:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [31:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic [`IRQ_LINES-1:0] line_req,
    output logic [`IRQ_LINES-1:0]      core_irq,
    output logic                       core_nmi,
    input  wire logic                  xtal_stopped,
    output logic                       system_clock_on_rc,
    input  wire logic                  wdog_active,
    input  wire logic                  wdog_restart,
    input  wire logic                  acc_valid,
    input  wire logic [31:0]           acc_addr,
    input  wire logic [1:0]            acc_size,
    input  wire logic                  acc_write,
    input  wire logic                  acc_user,
    input  wire logic                  acc_periph_bus,
    input  wire logic [11:0]           acc_last_reg,
    input  wire logic                  acc_system_periph,
    input  wire logic                  acc_protected_ram,
    input  wire logic                  acc_ram,
    input  wire logic                  acc_flash,
    output logic                       bus_fault_exc,
    output logic                       hard_fault_exc
);
    generate
        if (WDOG_WARN_CYCLES < 2 || SWITCH_CYCLES < 1 || SWITCH_CYCLES > 256) begin : g_chk
            $error("watchdog or switchover count out of range");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave
    logic        awready_r, awready_nxt, wready_r, wready_nxt;
    logic        bvalid_r, bvalid_nxt, arready_r, arready_nxt;
    logic        rvalid_r, rvalid_nxt;
    resp_t       bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    word_t       rdata_r, rdata_nxt;
    logic        aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
    word_t       awaddr_r, awaddr_nxt, wdata_r, wdata_nxt;
    logic [3:0]  wstrb_r, wstrb_nxt;
    logic        wr_fire;
    word_t       wbits;
    logic        wr_en_set, wr_nmi_flags, wr_nmi_mask, wr_nmi_miss;
    logic        wr_fault, wr_clock;
    logic                  rd_hit;
    word_t                 rd_word;
    logic [`IRQ_LINES-1:0] irq_en_r;
    logic [`FLT_BITS-1:0]  fault_r;
    clk_state_e            clk_state_r;

    sl_flags_if #(.N(`NMI_SRC)) nmi_sl ();

    assign wr_fire      = aw_held_r & w_held_r & ~bvalid_r;
    assign wbits        = wdata_r & {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                                     {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    assign wr_en_set    = wr_fire && awaddr_r == `OFS_IRQ_EN_SET;
    assign wr_nmi_flags = wr_fire && awaddr_r == `OFS_NMI_FLAGS;
    assign wr_nmi_mask  = wr_fire && awaddr_r == `OFS_NMI_MASK;
    assign wr_nmi_miss  = wr_fire && awaddr_r == `OFS_NMI_MISS;
    assign wr_fault     = wr_fire && awaddr_r == `OFS_FAULT_STATUS;
    assign wr_clock     = wr_fire && awaddr_r == `OFS_CLOCK_CTRL;

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = '0;
        case (s_axi_araddr)
            `OFS_IRQ_EN_SET:   rd_word = {15'h0000, irq_en_r};
            `OFS_NMI_FLAGS:    rd_word = {30'h00000000, nmi_sl.flags};
            `OFS_NMI_MASK:     rd_word = {30'h00000000, nmi_sl.mask};
            `OFS_NMI_MISS:     rd_word = {30'h00000000, nmi_sl.miss};
            `OFS_FAULT_STATUS: rd_word = {28'h0000000, fault_r};
            `OFS_CLOCK_CTRL:   rd_word = {31'h00000000, clk_state_r == CLK_RC};
            default:           rd_hit  = 1'b0;
        endcase
    end

    always_comb begin
        aw_held_nxt = aw_held_r | (s_axi_awvalid & awready_r);
        w_held_nxt  = w_held_r | (s_axi_wvalid & wready_r);
        awaddr_nxt  = (s_axi_awvalid & awready_r) ? s_axi_awaddr : awaddr_r;
        wdata_nxt   = (s_axi_wvalid & wready_r) ? s_axi_wdata : wdata_r;
        wstrb_nxt   = (s_axi_wvalid & wready_r) ? s_axi_wstrb : wstrb_r;
        bvalid_nxt  = bvalid_r & ~s_axi_bready;
        bresp_nxt   = bresp_r;
        if (wr_fire) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = (wr_en_set | wr_nmi_flags | wr_nmi_mask | wr_nmi_miss
                           | wr_fault | wr_clock) ? `RESP_OKAY : `RESP_SLVERR;
        end
        awready_nxt = ~aw_held_nxt & ~bvalid_nxt;
        wready_nxt  = ~w_held_nxt & ~bvalid_nxt;
        rvalid_nxt  = rvalid_r & ~s_axi_rready;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        if (s_axi_arvalid & arready_r) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = rd_word;
            rresp_nxt  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        arready_nxt = ~rvalid_nxt;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            rresp_r   <= `RESP_OKAY;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= '0;
            wstrb_r   <= '0;
        end else begin
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            awaddr_r  <= awaddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    ////////////////////////////////////////////////////////////////////////////
    // crystal failover and watchdog warning
    clk_state_e clk_state_nxt;
    logic [7:0]  sw_cnt_r, sw_cnt_nxt;
    logic [31:0] wd_cnt_r, wd_cnt_nxt;
    logic        on_rc_r, on_rc_nxt;
    logic        xtal_evt, wdog_evt;

    always_comb begin
        clk_state_nxt = clk_state_r;
        sw_cnt_nxt    = sw_cnt_r;
        xtal_evt      = 1'b0;
        case (clk_state_r)
            CLK_XTAL: begin
                if (xtal_stopped) begin
                    clk_state_nxt = CLK_SWITCH;
                    sw_cnt_nxt    = '0;
                end
            end
            CLK_SWITCH: begin
                sw_cnt_nxt = sw_cnt_r + 8'h01;
                if (sw_cnt_r == 8'(SWITCH_CYCLES - 1)) begin
                    clk_state_nxt = CLK_RC;
                    xtal_evt      = 1'b1;
                end
            end
            CLK_RC: begin
                if (wr_clock && wbits[`CLK_ON_RC_BIT] && !xtal_stopped) begin
                    clk_state_nxt = CLK_XTAL;
                end
            end
            default: clk_state_nxt = CLK_XTAL;
        endcase
        on_rc_nxt = (clk_state_nxt != CLK_XTAL);
        wdog_evt  = 1'b0;
        if (!wdog_active || wdog_restart) begin
            wd_cnt_nxt = '0;
        end else if (wd_cnt_r == 32'(WDOG_WARN_CYCLES - 1)) begin
            wd_cnt_nxt = 32'(WDOG_WARN_CYCLES);
            wdog_evt   = 1'b1;
        end else if (wd_cnt_r == 32'(WDOG_WARN_CYCLES)) begin
            wd_cnt_nxt = wd_cnt_r;
        end else begin
            wd_cnt_nxt = wd_cnt_r + 32'h00000001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            clk_state_r <= CLK_XTAL;
            sw_cnt_r    <= '0;
            wd_cnt_r    <= '0;
            on_rc_r     <= 1'b0;
        end else begin
            clk_state_r <= clk_state_nxt;
            sw_cnt_r    <= sw_cnt_nxt;
            wd_cnt_r    <= wd_cnt_nxt;
            on_rc_r     <= on_rc_nxt;
        end
    end

    assign system_clock_on_rc = on_rc_r;

    ////////////////////////////////////////////////////////////////////////////
    // non-maskable sources through the second-level flag group
    always_comb begin
        nmi_sl.event_in                = '0;
        nmi_sl.event_in[`NMI_XTAL_BIT] = xtal_evt;
        nmi_sl.event_in[`NMI_WDOG_BIT] = wdog_evt;
        nmi_sl.flag_clr   = wr_nmi_flags ? wbits[`NMI_SRC-1:0] : '0;
        nmi_sl.mask_wr_en = wr_nmi_mask;
        nmi_sl.mask_wdata = wbits[`NMI_SRC-1:0];
        nmi_sl.miss_clr   = wr_nmi_miss ? wbits[`NMI_SRC-1:0] : '0;
    end

    sl_flags #(
        .N        (`NMI_SRC),
        .MASK_RST (`NMI_MASK_RST)
    ) u_nmi_flags (
        .core_clk (core_clk),
        .srst     (srst),
        .sl       (nmi_sl.unit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus fault causes, top-level enables and core requests
    logic [`IRQ_LINES-1:0] irq_en_nxt, core_irq_r, core_irq_nxt;
    logic [`FLT_BITS-1:0]  fault_nxt, flt_new;
    logic                  nmi_r, bus_flt_r, bus_flt_nxt, hard_r, hard_nxt;
    logic                  any_new;

    always_comb begin
        flt_new = '0;
        flt_new[`FLT_BAD_WIDTH_BIT] = acc_valid
            & ((acc_periph_bus & acc_size != `SIZE_WORD)
               | (acc_size == `SIZE_WORD & acc_addr[1:0] != 2'h0));
        flt_new[`FLT_PROTECT_BIT] = acc_valid & acc_write & acc_user
            & (acc_system_periph | acc_protected_ram);
        flt_new[`FLT_RESERVED_BIT] = acc_valid
            & ((acc_periph_bus & acc_addr[11:0] > acc_last_reg)
               | (acc_ram & acc_addr > RAM_TOP)
               | (acc_flash & acc_addr > FLASH_TOP));
        any_new  = |flt_new;
        // a fault on top of a recorded one is the escalation case
        hard_nxt = any_new & (|fault_r);
        flt_new[`FLT_MISSED_BIT] = hard_nxt;
        fault_nxt = (fault_r & ~(wr_fault ? wbits[`FLT_BITS-1:0] : '0))
                  | flt_new;
        bus_flt_nxt = (|fault_nxt[`FLT_RESERVED_BIT:0]) & ~hard_nxt;
        irq_en_nxt = irq_en_r;
        if (wr_en_set) begin
            irq_en_nxt = irq_en_r | wbits[`IRQ_LINES-1:0];
        end
        core_irq_nxt = line_req & irq_en_nxt;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq_en_r   <= `IRQ_EN_RST;
            core_irq_r <= '0;
            fault_r    <= '0;
            bus_flt_r  <= 1'b0;
            hard_r     <= 1'b0;
            nmi_r      <= 1'b0;
        end else begin
            irq_en_r   <= irq_en_nxt;
            core_irq_r <= core_irq_nxt;
            fault_r    <= fault_nxt;
            bus_flt_r  <= bus_flt_nxt;
            hard_r     <= hard_nxt;
            nmi_r      <= nmi_sl.irq;
        end
    end

    assign core_irq       = core_irq_r;
    assign core_nmi       = nmi_r;
    assign bus_fault_exc  = bus_flt_r;
    assign hard_fault_exc = hard_r;
endmodule

// ---- nmi_fault_irq_enable_tb.sv ----
// self-checking bench for the interrupt, alarm and fault block
`timescale 1ns/1ps
`include "nmi_fault_params.svh"
module nmi_fault_irq_enable_tb
    import nmi_fault_pkg::*;
;
    localparam int WDOG = 20;
    logic core_clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, core_nmi, xtal_stopped, system_clock_on_rc, wdog_active;
    logic wdog_restart, acc_valid, acc_write, acc_user, acc_periph_bus, acc_flash;
    logic acc_system_periph, acc_protected_ram, acc_ram, bus_fault_exc, hard_fault_exc;
    logic xtal_kill, starve;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, acc_addr, seed, ra;
    logic [1:0]  s_axi_bresp, s_axi_rresp, acc_size, rsz;
    logic [3:0]  s_axi_wstrb, e1;
    logic [16:0] line_req, core_irq, en_m;
    logic [11:0] acc_last_reg;
    logic [6:0]  rf;
    int          fails, checks, cyc, i;

    nmi_fault_irq_enable #(.WDOG_WARN_CYCLES(WDOG)) uut (.*);
    alarm_src far_end (.*);

    ////////////////////////////////////////
    task automatic results;
        if (fails == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // f = {write, user, periph bus, system periph, protected ram, ram, flash}
    function automatic logic [3:0] fexp(input logic [31:0] a, input logic [1:0] sz,
                                        input logic [6:0] f);
        fexp[0] = (f[4] && sz != 2'h2) || (sz == 2'h2 && a[1:0] != 2'h0);
        fexp[1] = f[6] && f[5] && (f[3] || f[2]);
        fexp[2] = (f[4] && a[11:0] > acc_last_reg) || (f[1] && a > `RAM_TOP_DEF)
                  || (f[0] && a > `FLASH_TOP_DEF);
        fexp[3] = 1'b0;
    endfunction
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw;
        @(posedge core_clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        do begin
            @(negedge core_clk);
            ta = s_axi_awready || !s_axi_awvalid;
            tw = s_axi_wready || !s_axi_wvalid;
            @(posedge core_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!(ta && tw));
        do @(negedge core_clk); while (!s_axi_bvalid);
        chk(s_axi_bresp, er);
        @(posedge core_clk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge core_clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do @(negedge core_clk); while (!s_axi_arready);
        @(posedge core_clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge core_clk); while (!s_axi_rvalid);
        chk(s_axi_rdata, exp);
        chk(s_axi_rresp, er);
        @(posedge core_clk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic acc(input logic [31:0] a, input logic [1:0] sz, input logic [6:0] f);
        @(posedge core_clk);
        acc_addr <= a;
        acc_size <= sz;
        {acc_write, acc_user, acc_periph_bus, acc_system_periph, acc_protected_ram,
         acc_ram, acc_flash} <= f;
        acc_valid <= 1'b1;
        @(posedge core_clk);
        acc_valid <= 1'b0;
    endtask
    task automatic wait_nmi;
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (!core_nmi && n < 100);
        chk(core_nmi, 1'b1);
    endtask

    ////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, acc_addr} = 128'h0;
        {acc_valid, acc_write, acc_user, acc_periph_bus, acc_flash} = 5'h0;
        {acc_system_periph, acc_protected_ram, acc_ram, xtal_kill, starve} = 5'h0;
        s_axi_wstrb = 4'hf;
        acc_size = 2'h2;
        acc_last_reg = 12'h0fc;
        line_req = 17'h0;
        srst = 1'b1;
        seed = 32'h00015e88;
        en_m = 17'h0;
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        repeat (2) @(posedge core_clk);
        rdc(`OFS_IRQ_EN_SET, 32'h0, `RESP_OKAY);
        for (i = 0; i < 8; i++) begin
            seed = xs(seed);
            line_req <= seed[16:0];
            seed = xs(seed);
            ra = seed & (seed >> 7) & (seed >> 3);
            en_m = en_m | ra[16:0];
            wr(`OFS_IRQ_EN_SET, ra, `RESP_OKAY);
            rdc(`OFS_IRQ_EN_SET, {15'h0, en_m}, `RESP_OKAY);
            chk(core_irq, line_req & en_m);
        end
        rdc(32'he000e1fc, 32'h0, `RESP_SLVERR);
        wr(32'he000e1fc, 32'hffffffff, `RESP_SLVERR);
        for (i = 0; i < 12; i++) begin
            seed = xs(seed);
            ra = seed & 32'hffffff7f;
            seed = xs(seed);
            rsz = (seed[1:0] == 2'h3) ? 2'h2 : seed[1:0];
            rf = seed[8:2];
            e1 = fexp(ra, rsz, rf);
            acc(ra, rsz, rf);
            @(negedge core_clk);
            chk(bus_fault_exc, |e1[2:0]);
            rdc(`OFS_FAULT_STATUS, {28'h0, e1}, `RESP_OKAY);
            wr(`OFS_FAULT_STATUS, {28'h0, e1}, `RESP_OKAY);
        end
        acc(32'h00020000, 2'h2, 7'b0000001);
        acc(32'h40000010, 2'h0, 7'b1110100);
        @(negedge core_clk);
        chk(hard_fault_exc, 1'b1);
        rdc(`OFS_FAULT_STATUS, 32'hf, `RESP_OKAY);
        wr(`OFS_FAULT_STATUS, 32'hf, `RESP_OKAY);
        rdc(`OFS_NMI_MASK, 32'h3, `RESP_OKAY);
        @(posedge core_clk);
        xtal_kill <= 1'b1;
        wait_nmi();
        chk(system_clock_on_rc, 1'b1);
        rdc(`OFS_NMI_FLAGS, 32'h1, `RESP_OKAY);
        @(posedge core_clk);
        xtal_kill <= 1'b0;
        wr(`OFS_NMI_FLAGS, 32'h0, `RESP_OKAY);
        rdc(`OFS_NMI_FLAGS, 32'h1, `RESP_OKAY);
        wr(`OFS_NMI_FLAGS, 32'h1, `RESP_OKAY);
        wr(`OFS_CLOCK_CTRL, 32'h1, `RESP_OKAY);
        rdc(`OFS_CLOCK_CTRL, 32'h0, `RESP_OKAY);
        chk(core_nmi, 1'b0);
        @(posedge core_clk);
        starve <= 1'b1;
        wait_nmi();
        rdc(`OFS_NMI_FLAGS, 32'h2, `RESP_OKAY);
        @(posedge core_clk);
        starve <= 1'b0;
        wr(`OFS_NMI_FLAGS, 32'h2, `RESP_OKAY);
        @(negedge core_clk);
        chk(core_nmi, 1'b0);
        results();
    end
endmodule

bind nmi_fault_irq_enable nmi_fault_props #(.WDOG_WARN_CYCLES(WDOG_WARN_CYCLES)) props_i (.*);

// ---- nmi_fault_params.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef NMI_FAULT_PARAMS_SVH
`define NMI_FAULT_PARAMS_SVH

`define CLK_HZ              10000000
`define WDOG_WARN_MS        1792
`define WDOG_WARN_CYC       ((`CLK_HZ / 1000) * `WDOG_WARN_MS)
`define CLK_SWITCH_CYC      4

`define OFS_IRQ_EN_SET      32'he000e100
`define OFS_NMI_FLAGS       32'he000e110
`define OFS_NMI_MASK        32'he000e114
`define OFS_NMI_MISS        32'he000e118
`define OFS_FAULT_STATUS    32'he000e11c
`define OFS_CLOCK_CTRL      32'he000e120

`define IRQ_LINES           17
`define IRQ_EN_RST          17'h00000
`define NMI_SRC             2
`define NMI_MASK_RST        2'h3
`define NMI_XTAL_BIT        0
`define NMI_WDOG_BIT        1

`define FLT_BAD_WIDTH_BIT   0
`define FLT_PROTECT_BIT     1
`define FLT_RESERVED_BIT    2
`define FLT_MISSED_BIT      3
`define FLT_BITS            4

`define CLK_ON_RC_BIT       0
`define RAM_TOP_DEF         32'h0000ffff
`define FLASH_TOP_DEF       32'h0000ffff

`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`define SIZE_WORD           2'h2

`endif

// ---- nmi_fault_pkg.sv ----
// shared types of the interrupt, fault and clock-failover block
package nmi_fault_pkg;
    typedef enum logic [1:0] {
        CLK_XTAL   = 2'h0,
        CLK_SWITCH = 2'h1,
        CLK_RC     = 2'h3
    } clk_state_e;
    typedef logic [31:0] word_t;
    typedef logic [1:0]  resp_t;
endpackage

// ---- nmi_fault_props.sv ----
// concurrent checks on the interrupt, alarm and fault block ports
`timescale 1ns/1ps
module nmi_fault_props #(
    parameter int WDOG_WARN_CYCLES = 20
) (
    input wire logic        core_clk,
    input wire logic        srst,
    input wire logic [16:0] line_req,
    input wire logic [16:0] core_irq,
    input wire logic        core_nmi,
    input wire logic        xtal_stopped,
    input wire logic        system_clock_on_rc,
    input wire logic        wdog_active,
    input wire logic        wdog_restart,
    input wire logic        acc_valid,
    input wire logic [31:0] acc_addr,
    input wire logic [1:0]  acc_size,
    input wire logic        acc_write,
    input wire logic        acc_user,
    input wire logic        acc_periph_bus,
    input wire logic [11:0] acc_last_reg,
    input wire logic        acc_system_periph,
    input wire logic        acc_protected_ram,
    input wire logic        bus_fault_exc,
    input wire logic        hard_fault_exc
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    int unsigned wd_cnt_r;
    int unsigned wd_cnt_nxt;
    logic        any_fault;
    assign any_fault = bus_fault_exc | hard_fault_exc;
    // cycles of watchdog activity since the last restart, saturating
    always_comb begin
        wd_cnt_nxt = wd_cnt_r;
        if (!wdog_active || wdog_restart) wd_cnt_nxt = 0;
        else if (wd_cnt_r <= WDOG_WARN_CYCLES) wd_cnt_nxt = wd_cnt_r + 1;
    end
    always_ff @(posedge core_clk) begin
        if (srst) wd_cnt_r <= 0;
        else wd_cnt_r <= wd_cnt_nxt;
    end
    ////////////////////////////////////////
    a_irq_gated: assert property ((core_irq & ~$past(line_req)) == 17'h0)
        else $error("core irq without request");
    a_reset_quiet: assert property ($fell(srst) |-> core_irq == 17'h0 && !core_nmi)
        else $error("output active after reset");
    a_nmi_source: assert property ($rose(core_nmi) |-> system_clock_on_rc || $past(wd_cnt_r) == WDOG_WARN_CYCLES)
        else $error("nmi without alarm source");
    a_clock_switch: assert property (xtal_stopped && !system_clock_on_rc |-> ##[1:2] system_clock_on_rc)
        else $error("no switch to rc clock");
    a_switch_then_nmi: assert property ($rose(system_clock_on_rc) && !core_nmi |-> !core_nmi [*4] ##[1:3] core_nmi)
        else $error("crystal alarm timing wrong");
    a_wdog_warn: assert property (wd_cnt_r == WDOG_WARN_CYCLES |-> ##[0:4] core_nmi)
        else $error("watchdog warning missing");
    a_width_fault: assert property (acc_valid && ((acc_periph_bus && acc_size != 2'h2) || (acc_size == 2'h2 && acc_addr[1:0] != 2'h0)) |=> any_fault)
        else $error("width fault missing");
    a_protect_fault: assert property (acc_valid && acc_write && acc_user && (acc_system_periph || acc_protected_ram) |=> any_fault)
        else $error("protection fault missing");
    a_reserved_fault: assert property (acc_valid && acc_periph_bus && acc_addr[11:0] > acc_last_reg |=> any_fault)
        else $error("reserved fault missing");
    a_hard_pulse: assert property (hard_fault_exc |-> (!bus_fault_exc && $past(acc_valid)) ##1 !hard_fault_exc)
        else $error("hard fault shape wrong");
endmodule

// ---- sl_flags.sv ----
// second-level flag group: sticky flags, mask, missed-event bits
`timescale 1ns/1ps
`include "nmi_fault_params.svh"
module sl_flags
    import nmi_fault_pkg::*;
#(
    parameter int            N        = 2,
    parameter logic [N-1:0]  MASK_RST = '0
) (
    input  wire logic core_clk,
    input  wire logic srst,
    sl_flags_if.unit  sl
);
    logic [N-1:0] flags_r;
    logic [N-1:0] flags_nxt;
    logic [N-1:0] mask_r;
    logic [N-1:0] mask_nxt;
    logic [N-1:0] miss_r;
    logic [N-1:0] miss_nxt;

    generate
        if (N < 1) begin : g_chk
            $error("sl_flags needs at least one flag");
        end
    endgenerate

    always_comb begin
        // an event in the clearing cycle keeps its flag set
        flags_nxt = (flags_r & ~sl.flag_clr) | sl.event_in;
        mask_nxt  = sl.mask_wr_en ? sl.mask_wdata : mask_r;
        // repeat of an enabled, still-flagged event is dropped and noted
        miss_nxt  = (miss_r & ~sl.miss_clr)
                  | (sl.event_in & flags_r & mask_r & ~sl.flag_clr);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            flags_r <= '0;
            mask_r  <= MASK_RST;
            miss_r  <= '0;
        end else begin
            flags_r <= flags_nxt;
            mask_r  <= mask_nxt;
            miss_r  <= miss_nxt;
        end
    end

    assign sl.flags = flags_r;
    assign sl.mask  = mask_r;
    assign sl.miss  = miss_r;
    assign sl.irq   = |(flags_r & mask_r);
endmodule

// ---- sl_flags_if.sv ----
// link between register logic and one second-level flag group
`timescale 1ns/1ps
interface sl_flags_if #(parameter int N = 2);
    logic [N-1:0] event_in;
    logic [N-1:0] flag_clr;
    logic         mask_wr_en;
    logic [N-1:0] mask_wdata;
    logic [N-1:0] miss_clr;
    logic [N-1:0] flags;
    logic [N-1:0] mask;
    logic [N-1:0] miss;
    logic         irq;
    modport unit (input event_in, flag_clr, mask_wr_en, mask_wdata, miss_clr,
                  output flags, mask, miss, irq);
    modport ctrl (output event_in, flag_clr, mask_wr_en, mask_wdata, miss_clr,
                  input flags, mask, miss, irq);
endinterface
